//--- core/alu_ops_core.sv
// executor for literal/subroutine return, rotates, subtract, swap, direction load, xor
// Behaviour
// - literal return loads accumulator, pops, two cycles
// - literal return acts in Q4, second cycle idle
// - subroutine return pops into pc, two cycles
// - rotate left through carry, only carry changes
// - rotate right through carry, only carry changes
// - dest bit 0 accumulator, 1 file
// - subtract file minus accumulator, sets three flags
// - carry set unless negative; zero only for zero
// - swap nibbles into destination, flags untouched
// - direction load copies accumulator, selector five-seven
// - xor literal into accumulator, zero flag updated
// - xor file with accumulator, zero flag updated
`timescale 1ns/1ps
module alu_ops_core #(
    parameter int PC_W = 13
) (
    // clock and reset
    input  wire logic                       core_clk_in,
    input  wire logic                       arst_n_in,
    // apb slave
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [7:0]                 paddr_in,
    input  wire logic [31:0]                pwdata_in,
    output logic [31:0]                     prdata_out,
    output logic                            pready_out,
    output logic                            pslverr_out,
    // file register port
    output logic [6:0]                      file_addr_out,
    output logic                            file_rd_en_out,
    input  wire logic [7:0]                 file_rd_data_in,
    output logic                            file_wr_en_out,
    output logic [7:0]                      file_wr_data_out,
    // direction register port
    output logic                            dir_wr_en_out,
    output logic [2:0]                      dir_sel_out,
    output logic [7:0]                      dir_data_out,
    // stack and program counter
    input  wire logic [PC_W-1:0]            stack_head_in,
    output logic                            stack_pop_out,
    output logic                            pc_load_out,
    output logic [PC_W-1:0]                 pc_value_out,
    // phase
    output alu_ops_pkg::phase_e             phase_out
);
    import alu_ops_pkg::*;

    // ======================================================================
    // state
    phase_e                 phase_r;
    exec_e                  state_r;
    op_e                    op_r;
    logic [INSTR_W-1:0]     instr_r;
    logic                   pending_r;
    logic                   bad_r;
    logic [7:0]             acc_r;
    logic                   flag_c_r;
    logic                   flag_dc_r;
    logic                   flag_z_r;
    logic [7:0]             opnd_r;
    logic [7:0]             result_r;
    logic                   res_c_r;
    logic                   res_dc_r;
    logic                   res_z_r;
    logic                   to_acc_r;
    logic [31:0]            prdata_r;
    logic                   busy;
    logic                   run_q;
    logic                   apb_wr;
    logic                   mapped;
    logic                   instr_refused;
    logic [8:0]             diff_full;
    logic [4:0]             diff_low;
    logic [7:0]             res_nxt;
    logic                   c_nxt;
    logic                   dc_nxt;

    // ======================================================================
    // decode of an instruction word
    function automatic op_e decode(input logic [INSTR_W-1:0] w);
        op_e o;
        o = OP_NONE;
        if (w == OPC_RETURN) begin
            o = OP_RETURN;
        end else if (w[13:3] == OPC_DIR_HIGH && w[2:0] >= DIR_SEL_MIN) begin
            o = OP_DIR;
        end else if (w[13:12] == CLASS_LIT && w[11:10] == LIT_RET_SUB) begin
            o = OP_RETLIT;
        end else if (w[13:12] == CLASS_LIT && w[11:8] == LOP_XOR) begin
            o = OP_XORLIT;
        end else if (w[13:12] == CLASS_FILE) begin
            case (w[11:8])
                FOP_SUB:  o = OP_SUB;
                FOP_XOR:  o = OP_XORF;
                FOP_RRF:  o = OP_RRF;
                FOP_RLF:  o = OP_RLF;
                FOP_SWAP: o = OP_SWAP;
                default:  o = OP_NONE;
            endcase
        end
        return o;
    endfunction

    // ======================================================================
    // apb decode
    assign apb_wr        = psel_in && penable_in && pwrite_in;
    assign mapped        = (paddr_in == REG_INSTR) || (paddr_in == REG_ACC)
                           || (paddr_in == REG_STATUS);
    assign busy          = pending_r || (state_r != EX_IDLE);
    assign instr_refused = pwrite_in && (paddr_in == REG_INSTR) && busy;
    assign pready_out    = 1'b1;
    assign pslverr_out   = psel_in && penable_in && (!mapped || instr_refused);
    assign prdata_out    = prdata_r;

    // read data captured in the setup cycle
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            prdata_r <= 32'h0000_0000;
            case (paddr_in)
                REG_INSTR:  prdata_r[INSTR_W-1:0] <= instr_r;
                REG_ACC:    prdata_r[7:0] <= acc_r;
                REG_STATUS: begin
                    prdata_r[STAT_C]    <= flag_c_r;
                    prdata_r[STAT_DC]   <= flag_dc_r;
                    prdata_r[STAT_Z]    <= flag_z_r;
                    prdata_r[STAT_BUSY] <= busy;
                    prdata_r[STAT_BAD]  <= bad_r;
                end
                default:    prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // ======================================================================
    // free running quarter phase sequencer
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_r <= PH_Q1;
        end else begin
            case (phase_r)
                PH_Q1:   phase_r <= PH_Q2;
                PH_Q2:   phase_r <= PH_Q3;
                PH_Q3:   phase_r <= PH_Q4;
                PH_Q4:   phase_r <= PH_Q1;
                default: phase_r <= PH_Q1;
            endcase
        end
    end
    assign phase_out = phase_r;

    // ======================================================================
    // instruction intake and execution state
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            instr_r   <= INSTR_RST;
            pending_r <= 1'b0;
            state_r   <= EX_IDLE;
        end else begin
            if (apb_wr && paddr_in == REG_INSTR && !busy) begin
                instr_r   <= pwdata_in[INSTR_W-1:0];
                pending_r <= 1'b1;
            end
            case (state_r)
                EX_IDLE: if (pending_r && phase_r == PH_Q4) begin
                    state_r   <= EX_RUN;
                    pending_r <= 1'b0;
                end
                EX_RUN: if (phase_r == PH_Q4) begin
                    // returns spend a second cycle of no-operation phases
                    if (op_r == OP_RETLIT || op_r == OP_RETURN) begin
                        state_r <= EX_WAIT;
                    end else begin
                        state_r <= EX_IDLE;
                    end
                end
                EX_WAIT: if (phase_r == PH_Q4) begin
                    state_r <= EX_IDLE;
                end
                default: state_r <= EX_IDLE;
            endcase
        end
    end
    assign run_q = (state_r == EX_RUN);

    // ======================================================================
    // q1 decode and q2 operand read
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            op_r           <= OP_NONE;
            bad_r          <= 1'b0;
            opnd_r         <= 8'h00;
            file_addr_out  <= 7'h00;
            file_rd_en_out <= 1'b0;
        end else begin
            file_rd_en_out <= 1'b0;
            if (run_q && phase_r == PH_Q1) begin
                op_r           <= decode(instr_r);
                bad_r          <= (decode(instr_r) == OP_NONE);
                file_addr_out  <= instr_r[6:0];
                file_rd_en_out <= 1'b1;
            end
            if (run_q && phase_r == PH_Q2) begin
                opnd_r <= file_rd_data_in;
            end
        end
    end

    // ======================================================================
    // q3 processing: arithmetic and logic results
    assign diff_full = {1'b0, opnd_r} - {1'b0, acc_r};
    assign diff_low  = {1'b0, opnd_r[3:0]} - {1'b0, acc_r[3:0]};

    always_comb begin
        res_nxt = opnd_r;
        c_nxt   = flag_c_r;
        dc_nxt  = flag_dc_r;
        case (op_r)
            OP_RETLIT: res_nxt = instr_r[7:0];
            OP_RLF: begin
                res_nxt = {opnd_r[6:0], flag_c_r};
                c_nxt   = opnd_r[7];
            end
            OP_RRF: begin
                res_nxt = {flag_c_r, opnd_r[7:1]};
                c_nxt   = opnd_r[0];
            end
            OP_SUB: begin
                res_nxt = diff_full[7:0];
                c_nxt   = !diff_full[8];
                dc_nxt  = !diff_low[4];
            end
            OP_SWAP:   res_nxt = {opnd_r[3:0], opnd_r[7:4]};
            OP_DIR:    res_nxt = acc_r;
            OP_XORLIT: res_nxt = acc_r ^ instr_r[7:0];
            OP_XORF:   res_nxt = acc_r ^ opnd_r;
            default:   res_nxt = opnd_r;
        endcase
    end

    // results held for the write phase, strobes stand during q4
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            result_r         <= 8'h00;
            res_c_r          <= 1'b0;
            res_dc_r         <= 1'b0;
            res_z_r          <= 1'b0;
            to_acc_r         <= 1'b0;
            file_wr_en_out   <= 1'b0;
            file_wr_data_out <= 8'h00;
            dir_wr_en_out    <= 1'b0;
            dir_sel_out      <= 3'h0;
            dir_data_out     <= 8'h00;
            stack_pop_out    <= 1'b0;
            pc_load_out      <= 1'b0;
            pc_value_out     <= '0;
        end else begin
            file_wr_en_out <= 1'b0;
            dir_wr_en_out  <= 1'b0;
            stack_pop_out  <= 1'b0;
            pc_load_out    <= 1'b0;
            to_acc_r       <= 1'b0;
            if (run_q && phase_r == PH_Q3) begin
                result_r         <= res_nxt;
                res_c_r          <= c_nxt;
                res_dc_r         <= dc_nxt;
                res_z_r          <= (res_nxt == 8'h00);
                file_wr_data_out <= res_nxt;
                case (op_r)
                    OP_RLF, OP_RRF, OP_SUB, OP_SWAP, OP_XORF: begin
                        file_wr_en_out <= instr_r[DEST_BIT];
                        to_acc_r       <= !instr_r[DEST_BIT];
                    end
                    OP_RETLIT, OP_XORLIT: to_acc_r <= 1'b1;
                    OP_DIR: begin
                        dir_wr_en_out <= 1'b1;
                        dir_sel_out   <= instr_r[2:0];
                        dir_data_out  <= acc_r;
                    end
                    default: to_acc_r <= 1'b0;
                endcase
                if (op_r == OP_RETLIT || op_r == OP_RETURN) begin
                    stack_pop_out <= 1'b1;
                    pc_load_out   <= 1'b1;
                    pc_value_out  <= stack_head_in;
                end
            end
        end
    end

    // ======================================================================
    // q4 commit of accumulator and flags; core wins over a same-edge apb write
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            acc_r     <= ACC_RST;
            flag_c_r  <= 1'b0;
            flag_dc_r <= 1'b0;
            flag_z_r  <= 1'b0;
        end else if (run_q && phase_r == PH_Q4) begin
            if (to_acc_r) begin
                acc_r <= result_r;
            end
            if (op_r == OP_RLF || op_r == OP_RRF || op_r == OP_SUB) begin
                flag_c_r <= res_c_r;
            end
            if (op_r == OP_SUB) begin
                flag_dc_r <= res_dc_r;
            end
            if (op_r == OP_SUB || op_r == OP_XORLIT || op_r == OP_XORF) begin
                flag_z_r <= res_z_r;
            end
        end else if (apb_wr && paddr_in == REG_ACC) begin
            acc_r <= pwdata_in[7:0];
        end else if (apb_wr && paddr_in == REG_STATUS) begin
            flag_c_r  <= pwdata_in[STAT_C];
            flag_dc_r <= pwdata_in[STAT_DC];
            flag_z_r  <= pwdata_in[STAT_Z];
        end
    end

    // ======================================================================
    // assertions
    sequence s_ret_commit;
        run_q && phase_r == PH_Q4 && (op_r == OP_RETLIT || op_r == OP_RETURN);
    endsequence

    sequence s_idle_cycle;
        (state_r == EX_WAIT)[*4] ##1 (state_r == EX_IDLE);
    endsequence

    AST_RETLIT_ACC: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (run_q && phase_r == PH_Q4 && op_r == OP_RETLIT) |=> (acc_r == instr_r[7:0]))
        else $error("literal return did not load accumulator");

    AST_RET_TWO_CYCLES: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        s_ret_commit |=> s_idle_cycle)
        else $error("return did not take a second idle cycle");

    AST_POP_IN_Q4: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        stack_pop_out |-> (phase_r == PH_Q4 && pc_load_out
                           && pc_value_out == $past(stack_head_in)))
        else $error("stack pop outside q4 or wrong pc value");

    AST_RET_FLAGS: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (run_q && phase_r == PH_Q4 && (op_r == OP_RETURN || op_r == OP_SWAP))
        |=> {flag_c_r, flag_dc_r, flag_z_r} == $past({flag_c_r, flag_dc_r, flag_z_r}))
        else $error("flags changed on return or swap");

    AST_RLF_RESULT: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (run_q && phase_r == PH_Q3 && op_r == OP_RLF)
        |=> (result_r == {$past(opnd_r[6:0]), $past(flag_c_r)}) ##1 (flag_c_r == $past(res_c_r)))
        else $error("left rotate wrong");

    AST_RRF_RESULT: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (run_q && phase_r == PH_Q3 && op_r == OP_RRF)
        |=> (result_r == {$past(flag_c_r), $past(opnd_r[7:1])}) && res_c_r == $past(opnd_r[0]))
        else $error("right rotate wrong");

    AST_DEST_SELECT: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        file_wr_en_out |-> (instr_r[DEST_BIT] && !to_acc_r && phase_r == PH_Q4))
        else $error("file written with accumulator destination");

    AST_SUB_CARRY: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (run_q && phase_r == PH_Q3 && op_r == OP_SUB)
        |=> (res_c_r == ($past(opnd_r) >= $past(acc_r))) && (res_z_r == (result_r == 8'h00)))
        else $error("subtract carry or zero wrong");

    AST_DIR_LOAD: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        dir_wr_en_out |-> (dir_sel_out >= DIR_SEL_MIN && dir_sel_out <= DIR_SEL_MAX
                           && dir_data_out == acc_r))
        else $error("direction load bad selector or data");

    AST_XORLIT: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (run_q && phase_r == PH_Q2 && op_r == OP_XORLIT)
        |=> ##2 (acc_r == ($past(acc_r, 3) ^ instr_r[7:0])) && (flag_z_r == (acc_r == 8'h00)))
        else $error("xor literal wrong");

    AST_READ_Q2: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        file_rd_en_out |-> (phase_r == PH_Q2 && run_q))
        else $error("file read outside q2");

endmodule

//--- core/alu_ops_pkg.sv
// constants, register map and encodings for the return, rotate and logic op executor
package alu_ops_pkg;

    // ======================================================================
    // apb register map (byte addresses)
    localparam logic [7:0] REG_INSTR  = 8'h00;
    localparam logic [7:0] REG_ACC    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;

    // ======================================================================
    // status register fields
    localparam int STAT_C    = 0;
    localparam int STAT_DC   = 1;
    localparam int STAT_Z    = 2;
    localparam int STAT_BUSY = 8;
    localparam int STAT_BAD  = 9;

    // ======================================================================
    // instruction word layout
    localparam int INSTR_W  = 14;
    localparam int DEST_BIT = 7;
    localparam logic [1:0]  CLASS_FILE    = 2'h0;
    localparam logic [1:0]  CLASS_LIT     = 2'h3;
    localparam logic [1:0]  LIT_RET_SUB   = 2'h1;
    localparam logic [3:0]  FOP_SUB       = 4'h2;
    localparam logic [3:0]  FOP_XOR       = 4'h6;
    localparam logic [3:0]  FOP_RRF       = 4'hc;
    localparam logic [3:0]  FOP_RLF       = 4'hd;
    localparam logic [3:0]  FOP_SWAP      = 4'he;
    localparam logic [3:0]  LOP_XOR       = 4'ha;
    localparam logic [13:0] OPC_RETURN    = 14'h0008;
    localparam logic [10:0] OPC_DIR_HIGH  = 11'h00c;
    localparam logic [2:0]  DIR_SEL_MIN   = 3'h5;
    localparam logic [2:0]  DIR_SEL_MAX   = 3'h7;

    // ======================================================================
    // reset values
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [13:0] INSTR_RST = 14'h0000;

    // ======================================================================
    // quarter phases of one instruction cycle
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_e;

    // execution state
    typedef enum logic [2:0] {
        EX_IDLE = 3'b001,
        EX_RUN  = 3'b010,
        EX_WAIT = 3'b100
    } exec_e;

    // decoded operation
    typedef enum logic [9:0] {
        OP_NONE   = 10'b00_0000_0001,
        OP_RETLIT = 10'b00_0000_0010,
        OP_RETURN = 10'b00_0000_0100,
        OP_RLF    = 10'b00_0000_1000,
        OP_RRF    = 10'b00_0001_0000,
        OP_SUB    = 10'b00_0010_0000,
        OP_SWAP   = 10'b00_0100_0000,
        OP_DIR    = 10'b00_1000_0000,
        OP_XORLIT = 10'b01_0000_0000,
        OP_XORF   = 10'b10_0000_0000
    } op_e;

endpackage

//--- sim/cpu_return_rotate_logic_ops_tb_top.sv
// self-checking bench for the return, rotate and logic op executor
`timescale 1ns/1ps
module cpu_return_rotate_logic_ops_tb_top;
    import alu_ops_pkg::*;
    // ======================================================================
    // stimulus and observed signals
    logic        core_clk = 1'b0;
    logic        arst_n   = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [7:0]  frdata   = 8'h00;
    logic [12:0] shead    = 13'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, frd, fwr, dwr, pop, pcld;
    logic [6:0]  faddr;
    logic [7:0]  fwdata, ddata;
    logic [2:0]  dsel;
    logic [12:0] pcval;
    phase_e      ph;
    int          n_fail = 0;
    int          check_count = 0;
    int          seed = 88270;
    logic        wr_seen, dir_seen, pop_seen;
    logic [14:0] wr_c;
    logic [10:0] dir_c;
    logic [12:0] pc_c;

    alu_ops_core u_dut (.core_clk_in(core_clk), .arst_n_in(arst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .file_addr_out(faddr), .file_rd_en_out(frd), .file_rd_data_in(frdata),
        .file_wr_en_out(fwr), .file_wr_data_out(fwdata), .dir_wr_en_out(dwr),
        .dir_sel_out(dsel), .dir_data_out(ddata), .stack_head_in(shead),
        .stack_pop_out(pop), .pc_load_out(pcld), .pc_value_out(pcval), .phase_out(ph));

    // ======================================================================
    // clock, comparison and closing
    always #12.5 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // one apb transfer, idle cycle first so no signal is assigned twice
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // expected {nibble carry, carry, result}
    function automatic logic [9:0] calc(input int kind, input logic [7:0] w, f, k,
                                        input logic c);
        case (kind)
            2: calc = {1'b0, f[7], f[6:0], c};
            3: calc = {1'b0, f[0], c, f[7:1]};
            4: calc = {f[3:0] >= w[3:0], f >= w, f - w};
            5: calc = {1'b0, c, f[3:0], f[7:4]};
            7: calc = {1'b0, c, w ^ k};
            8: calc = {1'b0, c, w ^ f};
            default: calc = {1'b0, c, w};
        endcase
    endfunction

    // ======================================================================
    // strobe monitor
    always @(posedge core_clk) begin
        if (frd) check(ph, PH_Q2);
        if (fwr) begin
            wr_seen <= 1'b1;
            wr_c <= {faddr, fwdata};
            check(ph, PH_Q4);
        end
        if (dwr) begin
            dir_seen <= 1'b1;
            dir_c <= {dsel, ddata};
        end
        if (pop) begin
            pop_seen <= 1'b1;
            pc_c <= pcval;
            check({pcld, ph}, {1'b1, PH_Q4});
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        summarize();
    end

    // ======================================================================
    // main sequence: every opcode first, then random mix
    initial begin
        logic [3:0]  fops [9];
        logic [31:0] q;
        logic [13:0] instr;
        logic [9:0]  r;
        logic [7:0]  w, f, k, ew;
        logic [6:0]  fa;
        logic [2:0]  st, sel;
        logic        e, d, ec, edc, ez, fw, pe, de, busy;
        int          kind;
        fops = '{4'h0, 4'h0, FOP_RLF, FOP_RRF, FOP_SUB, FOP_SWAP, 4'h0, 4'h0, FOP_XOR};
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int it = 0; it < 70; it++) begin
            kind = (it < 18) ? it % 9 : $unsigned($random(seed)) % 9;
            {w, f, k, fa, st, d} = 35'({$random(seed), $random(seed)});
            sel = 3'h5 + 3'($unsigned($random(seed)) % 3);
            if (it == 13 || it % 7 == 3) f = w;
            frdata <= f;
            shead <= 13'($random(seed));
            wr_seen = 1'b0; dir_seen = 1'b0; pop_seen = 1'b0;
            apb(1'b1, REG_ACC, {24'h0, w}, q, e);
            apb(1'b1, REG_STATUS, {29'h0, st}, q, e);
            r = calc(kind, w, f, k, st[0]);
            {edc, ec, ez} = {st[1], st[0], st[2]};
            ew = w; fw = 1'b0; pe = 1'b0; de = 1'b0;
            case (kind)
                0: begin instr = {4'b1101, d, fa[0], k}; pe = 1'b1; ew = k; end
                1: begin instr = OPC_RETURN; pe = 1'b1; end
                6: begin instr = {OPC_DIR_HIGH, sel}; de = 1'b1; end
                7: begin instr = {CLASS_LIT, LOP_XOR, k}; ew = r[7:0]; end
                default: begin
                    instr = {CLASS_FILE, fops[kind], d, fa};
                    fw = d;
                    if (!d) ew = r[7:0];
                end
            endcase
            if (kind inside {2, 3, 4}) ec = r[8];
            if (kind == 4) edc = r[9];
            if (kind inside {4, 7, 8}) ez = (r[7:0] == 8'h00);
            apb(1'b1, REG_INSTR, {18'h0, instr}, q, e);
            if (kind == 0) begin
                apb(1'b1, REG_INSTR, {18'h0, OPC_RETURN}, q, e);
                check(e, 1'b1);
            end
            busy = 1'b1;
            for (int n = 0; n < 30 && busy; n++) begin
                apb(1'b0, REG_STATUS, 32'h0, q, e);
                busy = q[STAT_BUSY];
            end
            check(busy, 1'b0);
            apb(1'b0, REG_ACC, 32'h0, q, e);
            check(q, {24'h0, ew});
            apb(1'b0, REG_STATUS, 32'h0, q, e);
            check(q[9:0], {7'h0, ez, edc, ec});
            check({wr_seen, dir_seen, pop_seen}, {fw, de, pe});
            if (fw) check(wr_c, {fa, r[7:0]});
            if (de) check(dir_c, {sel, w});
            if (pe) check(pc_c, shead);
        end
        // direction load with a selector below five is refused as a no-op
        dir_seen = 1'b0;
        apb(1'b1, REG_INSTR, {18'h0, OPC_DIR_HIGH, 3'h4}, q, e);
        repeat (12) @(posedge core_clk);
        apb(1'b0, REG_STATUS, 32'h0, q, e);
        check({q[STAT_BAD], q[STAT_BUSY], dir_seen}, 3'b100);
        apb(1'b0, 8'h0c, 32'h0, q, e);
        check({e, q[30:0]}, {1'b1, 31'h0});
        summarize();
    end
endmodule
